/* File: shared/i2crs_pkg.sv */
package i2crs_pkg;

  localparam int PTR_W = 8;
  localparam int BYTE_W = 8;
  localparam int REG_COUNT = 256;

  // slave address bytes, write and read form
  localparam logic [7:0] WR_SLAVE_BYTE = 8'h8E;
  localparam logic [7:0] RD_SLAVE_BYTE = 8'h8F;

  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] CNT_RST = 3'h0;

  typedef enum logic [2:0] {
    LS_IDLE = 3'b000,
    LS_RX = 3'b001,
    LS_ACK = 3'b010,
    LS_TX = 3'b011,
    LS_MACK = 3'b100
  } i2crs_state_e;

  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_PTR = 2'b01,
    PH_WDATA = 2'b10,
    PH_READ = 2'b11
  } i2crs_phase_e;

  // register access request carried from link to core domain
  typedef struct packed {
    logic wr;
    logic [PTR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } i2crs_req_s;

  // write event shown to the user side
  typedef struct packed {
    logic valid;
    logic [PTR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } i2crs_wr_s;

endpackage

/* File: design/i2crs_slave.sv */
module i2crs_slave
  import i2crs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_link_clk,
  input wire logic i_serial_clock_pin,
  input wire logic i_serial_data_pin,
  output logic o_serial_data_pin,
  output logic o_serial_data_pin_oe,
  input wire logic [PTR_W-1:0] i_cfg_rd_addr,
  output logic [BYTE_W-1:0] o_cfg_rd_data,
  output i2crs_wr_s o_cfg_wr
);

  // reset release, one copy per domain
  logic rst_c1, rst_c2, rst_l1, rst_l2;
  logic rst_b, link_rst_b;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_c1 <= 1'b0;
      rst_c2 <= 1'b0;
    end else begin
      rst_c1 <= 1'b1;
      rst_c2 <= rst_c1;
    end
  end
  assign rst_b = rst_c2;

  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_l1 <= 1'b0;
      rst_l2 <= 1'b0;
    end else begin
      rst_l1 <= 1'b1;
      rst_l2 <= rst_l1;
    end
  end
  assign link_rst_b = rst_l2;

  // pin synchronisers on the link clock
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;

  always_ff @(posedge i_link_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s1 <= i_serial_clock_pin;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= i_serial_data_pin;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  logic scl_rise, scl_fall, start_cond, stop_cond;
  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_cond = scl_s2 & scl_d & ~sda_d & sda_s2;

  // link-side protocol engine
  i2crs_state_e state;
  i2crs_phase_e ph;
  logic [7:0] sh, tx, ptr, rd_byte;
  logic [2:0] cnt;
  logic full, mack_ok, sda_oe;
  i2crs_req_s req;
  logic req_tgl;
  logic ack_l1, ack_l2, ack_ld;
  logic ack_tgl;

  always_ff @(posedge i_link_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      state <= LS_IDLE;
      ph <= PH_ADDR;
      sh <= REG_RST;
      tx <= REG_RST;
      ptr <= PTR_RST;
      cnt <= CNT_RST;
      full <= 1'b0;
      mack_ok <= 1'b0;
      sda_oe <= 1'b0;
      req <= '0;
      req_tgl <= 1'b0;
    end else if (start_cond) begin
      // repeated and fresh start both restart the address phase
      state <= LS_RX;
      ph <= PH_ADDR;
      cnt <= CNT_RST;
      full <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop_cond) begin
      state <= LS_IDLE;
      full <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        LS_RX: begin
          if (scl_rise) begin
            sh <= {sh[6:0], sda_s2};
            cnt <= cnt + 3'h1;
            full <= (cnt == LAST_BIT);
          end else if (scl_fall && full) begin
            full <= 1'b0;
            state <= LS_ACK;
            sda_oe <= 1'b1;
            case (ph)
              PH_ADDR: begin
                if (sh == WR_SLAVE_BYTE) begin
                  ph <= PH_PTR;
                end else if (sh == RD_SLAVE_BYTE) begin
                  // fetch from the pointer as it stands
                  ph <= PH_READ;
                  req <= '{wr: 1'b0, addr: ptr, data: REG_RST};
                  req_tgl <= ~req_tgl;
                end else begin
                  state <= LS_IDLE;
                  sda_oe <= 1'b0;
                end
              end
              PH_PTR: begin
                ptr <= sh;
                ph <= PH_WDATA;
              end
              PH_WDATA: begin
                req <= '{wr: 1'b1, addr: ptr, data: sh};
                req_tgl <= ~req_tgl;
                ptr <= ptr + PTR_STEP;
              end
              default: begin
                state <= LS_IDLE;
                sda_oe <= 1'b0;
              end
            endcase
          end
        end
        LS_ACK: begin
          if (scl_fall) begin
            cnt <= CNT_RST;
            if (ph == PH_READ) begin
              state <= LS_TX;
              tx <= rd_byte;
              sda_oe <= ~rd_byte[7];
            end else begin
              state <= LS_RX;
              sda_oe <= 1'b0;
            end
          end
        end
        LS_TX: begin
          if (scl_fall) begin
            if (cnt == LAST_BIT) begin
              state <= LS_MACK;
              sda_oe <= 1'b0;
            end else begin
              tx <= {tx[6:0], 1'b0};
              sda_oe <= ~tx[6];
              cnt <= cnt + 3'h1;
            end
          end
        end
        LS_MACK: begin
          if (scl_rise) begin
            ptr <= ptr + PTR_STEP;
            if (!sda_s2) begin
              mack_ok <= 1'b1;
              req <= '{wr: 1'b0, addr: ptr + PTR_STEP, data: REG_RST};
              req_tgl <= ~req_tgl;
            end else begin
              // not-acknowledge: stay off the line until the next start
              state <= LS_IDLE;
            end
          end else if (scl_fall && mack_ok) begin
            mack_ok <= 1'b0;
            state <= LS_TX;
            cnt <= CNT_RST;
            tx <= rd_byte;
            sda_oe <= ~rd_byte[7];
          end
        end
        default: begin
          state <= LS_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  assign o_serial_data_pin = 1'b0;
  assign o_serial_data_pin_oe = sda_oe;

  // read data comes back with the answer toggle
  logic [7:0] core_rdata;

  always_ff @(posedge i_link_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      ack_l1 <= 1'b0;
      ack_l2 <= 1'b0;
      ack_ld <= 1'b0;
      rd_byte <= REG_RST;
    end else begin
      ack_l1 <= ack_tgl;
      ack_l2 <= ack_l1;
      ack_ld <= ack_l2;
      if (ack_l2 != ack_ld) begin
        rd_byte <= core_rdata;
      end
    end
  end

  // core side: register storage
  logic req_c1, req_c2, req_cd, req_evt;
  logic [7:0] regs [REG_COUNT];

  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_c1 <= 1'b0;
      req_c2 <= 1'b0;
      req_cd <= 1'b0;
    end else begin
      req_c1 <= req_tgl;
      req_c2 <= req_c1;
      req_cd <= req_c2;
    end
  end
  assign req_evt = req_c2 ^ req_cd;

  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= REG_RST;
      end
    end else if (req_evt && req.wr) begin
      regs[req.addr] <= req.data;
    end
  end

  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_rdata <= REG_RST;
      ack_tgl <= 1'b0;
      o_cfg_wr <= '0;
      o_cfg_rd_data <= REG_RST;
    end else begin
      o_cfg_rd_data <= regs[i_cfg_rd_addr];
      o_cfg_wr <= '{valid: req_evt & req.wr, addr: req.addr,
                    data: req.data};
      if (req_evt) begin
        core_rdata <= regs[req.addr];
        ack_tgl <= ~ack_tgl;
      end
    end
  end

  // checks on the link engine and the core answer
  addr_write_ack_a: assert property (
    @(posedge i_link_clk) disable iff (!link_rst_b)
    state == LS_RX && ph == PH_ADDR && full && scl_fall && !start_cond &&
    !stop_cond && sh == WR_SLAVE_BYTE
    |=> state == LS_ACK && sda_oe && ph == PH_PTR)
    else $error("write address not acknowledged");

  addr_read_ack_a: assert property (
    @(posedge i_link_clk) disable iff (!link_rst_b)
    state == LS_RX && ph == PH_ADDR && full && scl_fall && !start_cond &&
    !stop_cond && sh == RD_SLAVE_BYTE
    |=> state == LS_ACK && sda_oe && ph == PH_READ && !req.wr)
    else $error("read address not acknowledged");

  ptr_load_a: assert property (
    @(posedge i_link_clk) disable iff (!link_rst_b)
    state == LS_RX && ph == PH_PTR && full && scl_fall && !start_cond &&
    !stop_cond
    |=> ptr == $past(sh) && ph == PH_WDATA)
    else $error("pointer byte not loaded");

  write_req_a: assert property (
    @(posedge i_link_clk) disable iff (!link_rst_b)
    state == LS_RX && ph == PH_WDATA && full && scl_fall && !start_cond &&
    !stop_cond
    |=> req.wr && req.data == $past(sh) && req.addr == $past(ptr) &&
    req_tgl != $past(req_tgl))
    else $error("data byte not forwarded");

  ptr_step_a: assert property (
    @(posedge i_link_clk) disable iff (!link_rst_b)
    (state == LS_MACK && scl_rise && !start_cond && !stop_cond)
    |=> ptr == $past(ptr) + PTR_STEP)
    else $error("pointer did not step on acknowledge");

  read_first_a: assert property (
    @(posedge i_link_clk) disable iff (!link_rst_b)
    state == LS_ACK && ph == PH_READ && scl_fall && !start_cond &&
    !stop_cond
    |=> state == LS_TX && sda_oe == !$past(rd_byte[7]) && cnt == CNT_RST)
    else $error("first read bit not driven");

  seq_next_a: assert property (
    @(posedge i_link_clk) disable iff (!link_rst_b)
    state == LS_MACK && scl_rise && !sda_s2 && !start_cond && !stop_cond
    |=> !req.wr && req.addr == ptr && mack_ok)
    else $error("next byte not requested");

  nack_release_a: assert property (
    @(posedge i_link_clk) disable iff (!link_rst_b)
    state == LS_MACK && scl_rise && sda_s2 && !start_cond && !stop_cond
    |=> state == LS_IDLE && !sda_oe)
    else $error("line held after not-acknowledge");

  restart_a: assert property (
    @(posedge i_link_clk) disable iff (!link_rst_b)
    start_cond |=> state == LS_RX && ph == PH_ADDR && !sda_oe)
    else $error("start not taken");

  answer_a: assert property (
    @(posedge i_clk) disable iff (!rst_b)
    req_evt |=> ack_tgl != $past(ack_tgl) &&
    core_rdata == $past(regs[req.addr]))
    else $error("core did not answer request");

  cov_write_c: cover property (@(posedge i_link_clk)
    state == LS_RX && ph == PH_WDATA && full && scl_fall);
  cov_seq_read_c: cover property (@(posedge i_link_clk)
    state == LS_MACK && scl_rise && !sda_s2);
  cov_nack_c: cover property (@(posedge i_link_clk)
    state == LS_MACK && scl_rise && sda_s2);
  cov_restart_c: cover property (@(posedge i_link_clk)
    start_cond && state != LS_IDLE);

endmodule

/* File: bench/i2crs_master.sv */
module i2crs_master (
  output logic o_scl,
  output logic o_sda_low,
  input wire logic i_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int H = 1000;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // start from idle, or repeated start right after an ack bit
  task automatic start();
    o_sda_low = 1'b0;
    #H o_scl = 1'b1;
    #H o_sda_low = 1'b1;
    #H o_scl = 1'b0;
  endtask
  task automatic put(input logic b);
    o_sda_low = ~b;
    #H o_scl = 1'b1;
    #H o_scl = 1'b0;
  endtask
  task automatic get(output logic b);
    o_sda_low = 1'b0;
    #H o_scl = 1'b1;
    #(H / 2) b = i_sda;
    #(H / 2) o_scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(b);
    ack = ~b;
  endtask
  // read one byte, then ack it when ack is set, nack it otherwise
  task automatic rbyte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(~ack);
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    #H o_scl = 1'b1;
    #H o_sda_low = 1'b0;
    #H;
  endtask
endmodule

/* File: bench/i2crs_slave_tb.sv */
module i2crs_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import i2crs_pkg::*;
  logic clk, rst_b, link_clk, scl, sda_low, sdo, oe, a;
  wire logic sda;
  logic [7:0] rd_addr, rd_data, d;
  i2crs_wr_s wr, last_wr;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int nwr = 0;
  assign sda = sda_low ? 1'b0 : (oe ? sdo : 1'b1);
  i2crs_slave uut (.i_clk(clk), .i_rst_b(rst_b), .i_link_clk(link_clk),
    .i_serial_clock_pin(scl), .i_serial_data_pin(sda),
    .o_serial_data_pin(sdo), .o_serial_data_pin_oe(oe),
    .i_cfg_rd_addr(rd_addr), .o_cfg_rd_data(rd_data), .o_cfg_wr(wr));
  i2crs_master m (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end
  always @(negedge clk) begin
    cycles++;
    if (wr.valid === 1'b1) begin
      nwr++;
      last_wr = wr;
    end
    if (cycles == 40000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_ack(input logic exp);
    chk("ack", {7'h00, exp}, {7'h00, a});
  endtask
  task automatic peek(input logic [7:0] ad, input logic [7:0] exp);
    @(negedge clk) rd_addr = ad;
    repeat (2) @(negedge clk);
    chk("store", exp, rd_data);
  endtask
  task automatic t_page_write();
    logic [7:0] v [4] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4};
    m.start();
    m.wbyte(WR_SLAVE_BYTE, a);
    chk_ack(1'b1);
    m.wbyte(8'hFE, a);
    chk_ack(1'b1);
    foreach (v[i]) begin
      m.wbyte(v[i], a);
      chk_ack(1'b1);
    end
    m.stop();
    repeat (20) @(negedge clk);
    foreach (v[i]) peek(8'hFE + 8'(i), v[i]);
    chk("writes", 8'h04, nwr[7:0]);
    chk("wr addr", 8'h01, last_wr.addr);
    chk("wr data", 8'hD4, last_wr.data);
  endtask
  task automatic t_random_read();
    m.start();
    m.wbyte(WR_SLAVE_BYTE, a);
    m.wbyte(8'hFF, a);
    m.start();
    m.wbyte(RD_SLAVE_BYTE, a);
    chk_ack(1'b1);
    m.rbyte(1'b1, d);
    chk("rd ff", 8'hB2, d);
    m.rbyte(1'b0, d);
    chk("rd 00", 8'hC3, d);
    m.stop();
  endtask
  task automatic t_current_read();
    m.start();
    m.wbyte(RD_SLAVE_BYTE, a);
    chk_ack(1'b1);
    m.rbyte(1'b1, d);
    chk("rd 01", 8'hD4, d);
    m.rbyte(1'b0, d);
    chk("rd 02", 8'h00, d);
    m.rbyte(1'b0, d);
    chk("released", 8'hFF, d);
    m.stop();
  endtask
  task automatic t_refused();
    m.start();
    m.wbyte(8'h8C, a);
    chk_ack(1'b0);
    m.wbyte(8'h8D, a);
    chk_ack(1'b0);
    m.stop();
    peek(8'h8C, 8'h00);
    chk("writes", 8'h04, nwr[7:0]);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    rd_addr = 8'h00;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    repeat (10) @(negedge clk);
    chk("oe idle", 8'h00, {7'h00, oe});
    t_page_write();
    t_random_read();
    t_current_read();
    t_refused();
    tally_and_finish();
  end
endmodule
